//--- rtl/storage_link_frame_exchange.sv
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// ==================================================================
// Function
// - byte 0 must be the receive-data-block code, else negative reply.
// - offset nibble of byte 1 accepted only as 3, 7 or 15.
// - byte 2 low bits must match own node id, else negative reply.
// - byte 3 low bits must match initiator id seen at selection.
// - nonzero reserved bits still get positive reply, then packet silently dropped.
// - block length is 13 bits, low byte in byte 4, rest in byte 5.
// - seventh byte is xor of bytes 0 to 5; mismatch gives negative reply.
// - negative-reply checks come first and override every other outcome.
// - negative verdict may be decided per byte or after the whole descriptor.
// - valid descriptor starts payload phase with both phase lines low.
// - bad descriptor or parity leads to verdict phase with negative reply.
// - payload is counted bytes then one xor checksum byte.
// - payload good only with balanced strobes, length plus one bytes, no errors.
// - any length up to 8191 bytes is received.
// - error-free block over the limit is truncated and flagged oversize.
// - good payload gives positive reply; parity or checksum error gives negative.
// - verdict phase drives both phase lines high and sends one byte.
// - only 61h with parity 0 and 1Eh with parity 1 are sent.
// - after the reply the bus is released; positive reply forwards the packet unless reserved bits were set.
module storage_link_frame_exchange (
  input wire logic I_CLOCK,
  input wire logic I_RESET,
  input wire logic I_SELECTED,
  input wire logic [2:0] I_INITIATOR_ID,
  input wire logic I_RX_VALID,
  input wire logic [7:0] I_RX_DATA,
  input wire logic I_RX_PARITY,
  input wire logic I_STROBES_BALANCED,
  input wire logic I_TX_DONE,
  output logic O_CD,
  output logic O_IO,
  output logic O_TX_VALID,
  output logic [7:0] O_TX_DATA,
  output logic O_TX_PARITY,
  output logic O_BUS_FREE,
  output logic O_PAY_VALID,
  output logic [7:0] O_PAY_DATA,
  output logic O_DELIVER,
  output logic O_OVERSIZE,
  output storage_link_pkg::len_t O_DELIVER_LEN,
  input wire storage_link_pkg::addr_t I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire storage_link_pkg::addr_t I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY
);
  import storage_link_pkg::*;
  state_t state_reg, state_next;
  idx_t idx_reg;
  len_t len_reg, cnt_reg, limit;
  logic [2:0] node_id, init_id_reg;
  logic nak_reg, nak_next, rsv_reg, got_sum_reg;
  logic last_nak_reg, last_drop_reg;
  logic [15:0] dlv_cnt_reg, nak_cnt_reg;
  logic [7:0] acc;
  logic start, par_bad, desc_byte, last_desc, pay_byte, sum_byte;
  logic sum_bad, byte_nak, byte_rsv, ofs_ok, finish;
  // ==================================================================
  // register slave
  storage_link_axil_regs u_regs (
    .i_clock(I_CLOCK),
    .i_reset(I_RESET),
    .i_awaddr(I_AWADDR),
    .i_awvalid(I_AWVALID),
    .o_awready(O_AWREADY),
    .i_wdata(I_WDATA),
    .i_wstrb(I_WSTRB),
    .i_wvalid(I_WVALID),
    .o_wready(O_WREADY),
    .o_bresp(O_BRESP),
    .o_bvalid(O_BVALID),
    .i_bready(I_BREADY),
    .i_araddr(I_ARADDR),
    .i_arvalid(I_ARVALID),
    .o_arready(O_ARREADY),
    .o_rdata(O_RDATA),
    .o_rresp(O_RRESP),
    .o_rvalid(O_RVALID),
    .i_rready(I_RREADY),
    .i_status({26'h0000000, last_drop_reg, last_nak_reg, state_reg}),
    .i_counts({nak_cnt_reg, dlv_cnt_reg}),
    .o_node_id(node_id),
    .o_body_limit(limit)
  );
  // ==================================================================
  // checksum accumulator
  storage_link_xor_acc u_acc (
    .i_clock(I_CLOCK),
    .i_reset(I_RESET),
    .i_clear(start || last_desc),
    .i_add(desc_byte || (pay_byte && !sum_byte)),
    .i_byte(I_RX_DATA),
    .o_acc(acc)
  );
  // ==================================================================
  // per-byte checks
  always_comb begin
    start = (state_reg == S_IDLE) && I_SELECTED;
    finish = (state_reg == S_STAT) && I_TX_DONE;
    par_bad = ~(^{I_RX_PARITY, I_RX_DATA});
    desc_byte = (state_reg == S_CMD) && I_RX_VALID;
    last_desc = desc_byte && (idx_reg == B_SUM);
    pay_byte = (state_reg == S_DATA) && I_RX_VALID && !got_sum_reg;
    sum_byte = pay_byte && (cnt_reg == len_reg);
    sum_bad = (acc != I_RX_DATA);
    ofs_ok = (I_RX_DATA[7:OFS_LSB] == OFS_A) || (I_RX_DATA[7:OFS_LSB] == OFS_B) ||
             (I_RX_DATA[7:OFS_LSB] == OFS_C);
    byte_nak = par_bad;
    byte_rsv = 1'b0;
    case (idx_reg)
      B_OP: byte_nak = par_bad || (I_RX_DATA != OPCODE_RECV);
      B_OFS: byte_nak = par_bad || !ofs_ok;
      B_DST: begin
        byte_nak = par_bad || (I_RX_DATA[ID_MSB:0] != node_id);
        byte_rsv = |I_RX_DATA[7:RSV_LSB];
      end
      B_SRC: begin
        byte_nak = par_bad || (I_RX_DATA[ID_MSB:0] != init_id_reg);
        byte_rsv = |I_RX_DATA[7:RSV_LSB];
      end
      B_LENH: byte_rsv = |I_RX_DATA[7:RSV5_LSB];
      B_SUM: byte_nak = par_bad || sum_bad;
      default: byte_nak = par_bad;
    endcase
  end
  // ==================================================================
  // negative verdict, decided per byte and acted on at phase end
  always_comb begin
    nak_next = nak_reg;
    if (start) begin
      nak_next = 1'b0;
    end else if (desc_byte && byte_nak) begin
      nak_next = 1'b1;
    end else if (pay_byte && (par_bad || (sum_byte && sum_bad))) begin
      nak_next = 1'b1;
    end else if ((state_reg == S_DATA) && I_RX_VALID && got_sum_reg) begin
      nak_next = 1'b1;
    end
  end
  // ==================================================================
  // phase sequencing
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      S_IDLE: if (I_SELECTED) begin
        state_next = S_CMD;
      end
      S_CMD: if (last_desc) begin
        state_next = nak_next ? S_STAT : S_DATA;
      end
      S_DATA: if (got_sum_reg && I_STROBES_BALANCED) begin
        state_next = S_STAT;
      end
      S_STAT: if (I_TX_DONE) begin
        state_next = S_IDLE;
      end
    endcase
  end
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      state_reg <= S_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end
  // ==================================================================
  // phase lines and verdict byte
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      O_CD <= 1'b0;
      O_IO <= 1'b0;
      O_TX_VALID <= 1'b0;
      O_TX_DATA <= ACK_CODE;
      O_TX_PARITY <= ACK_PAR;
      O_BUS_FREE <= 1'b0;
    end else begin
      O_CD <= (state_next == S_CMD) || (state_next == S_STAT);
      O_IO <= (state_next == S_STAT);
      O_TX_VALID <= (state_next == S_STAT);
      O_TX_DATA <= nak_next ? NAK_CODE : ACK_CODE;
      O_TX_PARITY <= nak_next ? NAK_PAR : ACK_PAR;
      O_BUS_FREE <= finish;
    end
  end
  // ==================================================================
  // descriptor fields
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      idx_reg <= B_OP;
      len_reg <= '0;
      init_id_reg <= 3'h0;
      nak_reg <= 1'b0;
      rsv_reg <= 1'b0;
    end else begin
      nak_reg <= nak_next;
      if (start) begin
        idx_reg <= B_OP;
        init_id_reg <= I_INITIATOR_ID;
        rsv_reg <= 1'b0;
      end else if (desc_byte) begin
        idx_reg <= idx_reg + 3'h1;
        if (byte_rsv) begin
          rsv_reg <= 1'b1;
        end
        if (idx_reg == B_LENL) begin
          len_reg[7:0] <= I_RX_DATA;
        end
        if (idx_reg == B_LENH) begin
          len_reg[12:8] <= I_RX_DATA[LENH_MSB:0];
        end
      end
    end
  end
  // ==================================================================
  // payload count and stream, no length rejected
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      cnt_reg <= '0;
      got_sum_reg <= 1'b0;
      O_PAY_VALID <= 1'b0;
      O_PAY_DATA <= 8'h00;
    end else begin
      O_PAY_VALID <= pay_byte && !sum_byte && (cnt_reg < limit);
      O_PAY_DATA <= I_RX_DATA;
      if (start) begin
        cnt_reg <= '0;
        got_sum_reg <= 1'b0;
      end else if (sum_byte) begin
        got_sum_reg <= 1'b1;
      end else if (pay_byte) begin
        cnt_reg <= cnt_reg + 13'h0001;
      end
    end
  end
  // ==================================================================
  // delivery upward
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      O_DELIVER <= 1'b0;
      O_OVERSIZE <= 1'b0;
      O_DELIVER_LEN <= '0;
      last_nak_reg <= 1'b0;
      last_drop_reg <= 1'b0;
    end else begin
      O_DELIVER <= finish && !nak_reg && !rsv_reg;
      if (finish) begin
        O_OVERSIZE <= !nak_reg && !rsv_reg && (len_reg > limit);
        O_DELIVER_LEN <= (len_reg > limit) ? limit : len_reg;
        last_nak_reg <= nak_reg;
        last_drop_reg <= !nak_reg && rsv_reg;
      end
    end
  end
  // ==================================================================
  // frame counters
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      dlv_cnt_reg <= 16'h0000;
      nak_cnt_reg <= 16'h0000;
    end else begin
      if (finish && !nak_reg && !rsv_reg) begin
        dlv_cnt_reg <= dlv_cnt_reg + 16'h0001;
      end
      if (finish && nak_reg) begin
        nak_cnt_reg <= nak_cnt_reg + 16'h0001;
      end
    end
  end
  // ==================================================================
  // checks
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (I_RESET);
  property p_opcode;
    desc_byte && (idx_reg == B_OP) && (I_RX_DATA != OPCODE_RECV) |=> nak_reg;
  endproperty
  a_opcode: assert property (p_opcode) else $error("bad opcode not refused");
  property p_offset;
    desc_byte && (idx_reg == B_OFS) && !ofs_ok |=> nak_reg;
  endproperty
  a_offset: assert property (p_offset) else $error("bad offset not refused");
  property p_dest;
    desc_byte && (idx_reg == B_DST) && (I_RX_DATA[ID_MSB:0] != node_id) |=> nak_reg;
  endproperty
  a_dest: assert property (p_dest) else $error("foreign node id accepted");
  property p_src;
    desc_byte && (idx_reg == B_SRC) && (I_RX_DATA[ID_MSB:0] != init_id_reg) |=> nak_reg;
  endproperty
  a_src: assert property (p_src) else $error("source id mismatch accepted");
  property p_sum;
    last_desc && sum_bad |=> (state_reg == S_STAT) && O_TX_DATA == NAK_CODE;
  endproperty
  a_sum: assert property (p_sum) else $error("descriptor checksum not refused");
  property p_data_lines;
    (state_reg == S_DATA) |-> !O_CD && !O_IO && !O_TX_VALID;
  endproperty
  a_data_lines: assert property (p_data_lines) else $error("payload phase lines wrong");
  property p_stat_lines;
    (state_reg == S_STAT) |-> O_CD && O_IO && O_TX_VALID;
  endproperty
  a_stat_lines: assert property (p_stat_lines) else $error("verdict phase lines wrong");
  property p_code;
    O_TX_VALID |-> (O_TX_DATA == ACK_CODE && O_TX_PARITY == ACK_PAR) ||
                   (O_TX_DATA == NAK_CODE && O_TX_PARITY == NAK_PAR);
  endproperty
  a_code: assert property (p_code) else $error("illegal reply byte");
  property p_free;
    finish |=> (state_reg == S_IDLE) && O_BUS_FREE && !O_CD && !O_IO;
  endproperty
  a_free: assert property (p_free) else $error("bus not released after reply");
  property p_deliver;
    O_DELIVER |-> $past(nak_reg) == 1'b0 && $past(rsv_reg) == 1'b0 && O_BUS_FREE;
  endproperty
  a_deliver: assert property (p_deliver) else $error("bad packet delivered");
  property p_pay_nak;
    pay_byte && par_bad |=> nak_reg ##1 1'b1;
  endproperty
  a_pay_nak: assert property (p_pay_nak) else $error("payload parity error missed");
  property p_balance;
    (state_reg == S_DATA) && !I_STROBES_BALANCED |=> (state_reg != S_STAT);
  endproperty
  a_balance: assert property (p_balance) else $error("phase changed with open strobes");
endmodule
`default_nettype wire

//--- rtl/storage_link_pkg.sv
// ==================================================================
// shared constants and types
package storage_link_pkg;
  localparam int LEN_W = 13;
  localparam int ADDR_W = 4;
  typedef logic [LEN_W-1:0] len_t;
  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [2:0] idx_t;
  // ================================================================
  // descriptor layout
  localparam idx_t B_OP = 3'h0;
  localparam idx_t B_OFS = 3'h1;
  localparam idx_t B_DST = 3'h2;
  localparam idx_t B_SRC = 3'h3;
  localparam idx_t B_LENL = 3'h4;
  localparam idx_t B_LENH = 3'h5;
  localparam idx_t B_SUM = 3'h6;
  localparam logic [7:0] OPCODE_RECV = 8'hE0;
  localparam int OFS_LSB = 4;
  localparam int ID_MSB = 2;
  localparam int RSV_LSB = 3;
  localparam int LENH_MSB = 4;
  localparam int RSV5_LSB = 5;
  localparam logic [3:0] OFS_A = 4'h3;
  localparam logic [3:0] OFS_B = 4'h7;
  localparam logic [3:0] OFS_C = 4'hF;
  // ================================================================
  // verdict codes, odd parity
  localparam logic [7:0] ACK_CODE = 8'h61;
  localparam logic ACK_PAR = 1'b0;
  localparam logic [7:0] NAK_CODE = 8'h1E;
  localparam logic NAK_PAR = 1'b1;
  // ================================================================
  // register map
  localparam addr_t REG_CFG = 4'h0;
  localparam addr_t REG_LIMIT = 4'h4;
  localparam addr_t REG_STATUS = 4'h8;
  localparam addr_t REG_COUNT = 4'hC;
  localparam logic [2:0] NODE_ID_RESET = 3'h0;
  localparam len_t LIMIT_RESET = 13'h1FFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ================================================================
  // phases
  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_CMD = 4'h2,
    S_DATA = 4'h4,
    S_STAT = 4'h8
  } state_t;
endpackage

//--- rtl/storage_link_xor_acc.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================================
// running xor of received bytes
module storage_link_xor_acc (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_clear,
  input wire logic i_add,
  input wire logic [7:0] i_byte,
  output logic [7:0] o_acc
);
  import storage_link_pkg::*;
  always_ff @(posedge i_clock) begin
    if (i_reset || i_clear) begin
      o_acc <= 8'h00;
    end else if (i_add) begin
      o_acc <= o_acc ^ i_byte;
    end
  end
endmodule
`default_nettype wire

//--- rtl/storage_link_axil_regs.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================================
// axi4-lite register slave
module storage_link_axil_regs (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire storage_link_pkg::addr_t i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire storage_link_pkg::addr_t i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic [31:0] i_status,
  input wire logic [31:0] i_counts,
  output logic [2:0] o_node_id,
  output storage_link_pkg::len_t o_body_limit
);
  import storage_link_pkg::*;
  addr_t aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic do_write;
  assign do_write = !o_awready && !o_wready && !o_bvalid;
  // ================================================================
  // write channels, taken in either order
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_bvalid <= 1'b0;
      o_bresp <= RESP_OKAY;
      aw_addr_reg <= '0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end else begin
      if (o_awready && i_awvalid) begin
        o_awready <= 1'b0;
        aw_addr_reg <= i_awaddr;
      end
      if (o_wready && i_wvalid) begin
        o_wready <= 1'b0;
        w_data_reg <= i_wdata;
        w_strb_reg <= i_wstrb;
      end
      if (do_write) begin
        o_bvalid <= 1'b1;
        o_bresp <= (aw_addr_reg == REG_CFG || aw_addr_reg == REG_LIMIT ||
                    aw_addr_reg == REG_STATUS || aw_addr_reg == REG_COUNT) ?
                   RESP_OKAY : RESP_SLVERR;
      end
      if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end
  // ================================================================
  // writable fields
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_node_id <= NODE_ID_RESET;
      o_body_limit <= LIMIT_RESET;
    end else if (do_write) begin
      if (aw_addr_reg == REG_CFG && w_strb_reg[0]) begin
        o_node_id <= w_data_reg[2:0];
      end
      if (aw_addr_reg == REG_LIMIT && w_strb_reg[0]) begin
        o_body_limit[7:0] <= w_data_reg[7:0];
      end
      if (aw_addr_reg == REG_LIMIT && w_strb_reg[1]) begin
        o_body_limit[12:8] <= w_data_reg[12:8];
      end
    end
  end
  // ================================================================
  // read channel
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h00000000;
      o_rresp <= RESP_OKAY;
    end else if (o_arready && i_arvalid) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rresp <= RESP_OKAY;
      unique case (i_araddr)
        REG_CFG: o_rdata <= {29'h00000000, o_node_id};
        REG_LIMIT: o_rdata <= {19'h00000, o_body_limit};
        REG_STATUS: o_rdata <= i_status;
        REG_COUNT: o_rdata <= i_counts;
        default: begin
          o_rdata <= 32'h00000000;
          o_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- dv/storage_link_initiator_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================================
// initiator side of the link
module storage_link_initiator_model (
  input wire logic i_clock,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_selected,
  output logic [2:0] o_id,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic o_rx_parity,
  output logic o_balanced,
  output logic o_tx_done
);
  int slow = 0;
  int cnt = 0;
  int flip = -1;
  logic held = 1'b0;
  logic [7:0] reply = 8'h00;
  initial begin
    o_selected = 1'b0;
    o_id = 3'h0;
    o_rx_valid = 1'b0;
    o_rx_data = 8'h00;
    o_rx_parity = 1'b1;
    o_balanced = 1'b1;
    o_tx_done = 1'b0;
  end
  // ================================================================
  // reply handshake, prompt or slow
  always @(posedge i_clock) begin
    o_tx_done <= i_tx_valid && !held && cnt == slow && !o_tx_done;
    held <= i_tx_valid && (held || o_tx_done);
    cnt <= i_tx_valid ? cnt + 1 : 0;
    if (o_tx_done) reply <= i_tx_data;
  end
  task select(input logic [2:0] id);
    @(posedge i_clock);
    o_selected <= 1'b1;
    o_id <= id;
    @(posedge i_clock);
    o_selected <= 1'b0;
  endtask
  // ================================================================
  // bytes back to back, odd parity, stale data inverted
  task automatic send(input logic [7:0] q[$]);
    foreach (q[k]) begin
      @(posedge i_clock);
      o_rx_valid <= 1'b1;
      o_rx_data <= q[k];
      o_rx_parity <= ~^q[k] ^ (k == flip);
      o_balanced <= 1'b0;
    end
    @(posedge i_clock);
    o_rx_valid <= 1'b0;
    o_rx_data <= ~o_rx_data;
    @(posedge i_clock);
    o_balanced <= 1'b1;
  endtask
endmodule
`default_nettype wire

//--- dv/test_storage_link_frame_exchange.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================================
// self-checking bench
module test_storage_link_frame_exchange;
  import storage_link_pkg::*;
  logic I_CLOCK = 1'b0;
  logic I_RESET = 1'b1;
  logic I_AWVALID = 1'b0, I_WVALID = 1'b0, I_BREADY = 1'b0, I_ARVALID = 1'b0, I_RREADY = 1'b0;
  addr_t I_AWADDR = 4'h0, I_ARADDR = 4'h0;
  logic [31:0] I_WDATA = 32'h0;
  logic [3:0] I_WSTRB = 4'hF;
  wire sel, rxv, rxp, bal, txd;
  wire [2:0] iid_w;
  wire [7:0] rxd;
  logic O_CD, O_IO, O_TX_VALID, O_TX_PARITY, O_BUS_FREE, O_PAY_VALID, O_DELIVER, O_OVERSIZE;
  logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID;
  logic [7:0] O_TX_DATA, O_PAY_DATA;
  len_t O_DELIVER_LEN;
  len_t limit = LIMIT_RESET;
  logic [1:0] O_BRESP, O_RRESP;
  logic [31:0] O_RDATA;
  logic [2:0] node, iid;
  logic [7:0] got[$], sent[$];
  int fail_count = 0, total_checks = 0, cycles = 0, seed = 32;
  int rsv_at = 2, dlv = 0, naks = 0;
  logic [3:0] ofs_list[3] = '{OFS_A, OFS_B, OFS_C};
  always #20 I_CLOCK = ~I_CLOCK;
  storage_link_frame_exchange dut_u (
    .I_CLOCK(I_CLOCK), .I_RESET(I_RESET), .I_SELECTED(sel), .I_INITIATOR_ID(iid_w),
    .I_RX_VALID(rxv), .I_RX_DATA(rxd), .I_RX_PARITY(rxp), .I_STROBES_BALANCED(bal),
    .I_TX_DONE(txd), .O_CD(O_CD), .O_IO(O_IO), .O_TX_VALID(O_TX_VALID),
    .O_TX_DATA(O_TX_DATA), .O_TX_PARITY(O_TX_PARITY), .O_BUS_FREE(O_BUS_FREE),
    .O_PAY_VALID(O_PAY_VALID), .O_PAY_DATA(O_PAY_DATA), .O_DELIVER(O_DELIVER),
    .O_OVERSIZE(O_OVERSIZE), .O_DELIVER_LEN(O_DELIVER_LEN), .I_AWADDR(I_AWADDR),
    .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY), .I_WDATA(I_WDATA), .I_WSTRB(I_WSTRB),
    .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .O_BRESP(O_BRESP), .O_BVALID(O_BVALID),
    .I_BREADY(I_BREADY), .I_ARADDR(I_ARADDR), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY),
    .O_RDATA(O_RDATA), .O_RRESP(O_RRESP), .O_RVALID(O_RVALID), .I_RREADY(I_RREADY)
  );
  storage_link_initiator_model init_u (
    .i_clock(I_CLOCK), .i_tx_valid(O_TX_VALID), .i_tx_data(O_TX_DATA), .o_selected(sel),
    .o_id(iid_w), .o_rx_valid(rxv), .o_rx_data(rxd), .o_rx_parity(rxp), .o_balanced(bal),
    .o_tx_done(txd)
  );
  // ================================================================
  // payload monitor and hang limit, longest frame is about 8200 cycles
  always @(posedge I_CLOCK) begin
    cycles <= cycles + 1;
    if (O_PAY_VALID === 1'b1) got.push_back(O_PAY_DATA);
    if (cycles == 40000) begin
      fail_count++;
      results();
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      fail_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task results;
    if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ================================================================
  // axi4-lite master
  task axw(input addr_t a, input logic [31:0] d);
    @(posedge I_CLOCK);
    I_AWADDR <= a;
    I_WDATA <= d;
    I_AWVALID <= 1'b1;
    I_WVALID <= 1'b1;
    I_BREADY <= 1'b1;
    do begin
      @(posedge I_CLOCK);
      if (O_AWREADY === 1'b1) I_AWVALID <= 1'b0;
      if (O_WREADY === 1'b1) I_WVALID <= 1'b0;
    end while (O_BVALID !== 1'b1);
    I_BREADY <= 1'b0;
    check(O_BRESP, RESP_OKAY);
  endtask
  task axr(input addr_t a, input logic [31:0] d);
    @(posedge I_CLOCK);
    I_ARADDR <= a;
    I_ARVALID <= 1'b1;
    I_RREADY <= 1'b1;
    do begin
      @(posedge I_CLOCK);
      if (O_ARREADY === 1'b1) I_ARVALID <= 1'b0;
    end while (O_RVALID !== 1'b1);
    I_RREADY <= 1'b0;
    check(O_RDATA, d);
    check(O_RRESP, a[1:0] == 2'b00 ? RESP_OKAY : RESP_SLVERR);
  endtask
  // ================================================================
  // one whole exchange with expectations
  task automatic frame(input logic [7:0] op, input logic [3:0] ofs, input logic [2:0] dst,
      input logic [2:0] src, input logic [4:0] rsv, input int len, input int bad);
    logic [7:0] q[$];
    logic [7:0] x;
    logic nak;
    int n;
    nak = op !== OPCODE_RECV || !(ofs inside {OFS_A, OFS_B, OFS_C}) || dst !== node;
    nak = nak || src !== iid || bad inside {1, 3};
    q = '{op, {ofs, 4'h0}, {rsv_at == 2 ? rsv : 5'h00, dst}, {rsv_at == 3 ? rsv : 5'h00, src},
        len[7:0], {rsv_at == 5 ? rsv[4:2] : 3'h0, len[12:8]}};
    x = 8'h00;
    foreach (q[k]) x ^= q[k];
    q.push_back(x ^ (bad == 1 ? 8'h01 : 8'h00));
    init_u.slow = $unsigned($random(seed)) % 4;
    init_u.select(iid);
    for (n = 0; n < 9 && O_CD !== 1'b1; n++) @(negedge I_CLOCK);
    init_u.flip = bad == 3 ? 3 : -1;
    init_u.send(q);
    @(negedge I_CLOCK);
    check({O_CD, O_IO}, {nak, nak});
    if ({O_CD, O_IO} !== {nak, nak}) begin
      @(posedge I_CLOCK);
      I_RESET <= 1'b1;
      @(posedge I_CLOCK);
      I_RESET <= 1'b0;
      return;
    end
    if (!nak) begin
      sent.delete();
      got.delete();
      x = 8'h00;
      for (n = 0; n < len; n++) sent.push_back(8'($random(seed)));
      foreach (sent[k]) x ^= sent[k];
      q = sent;
      q.push_back(x ^ (bad == 2 ? 8'h80 : 8'h00));
      if (bad == 5) q.push_back(8'h00);
      init_u.flip = bad == 4 ? 1 : -1;
      init_u.send(q);
      nak = bad inside {2, 4, 5};
    end
    for (n = 0; n < 9 && O_TX_VALID !== 1'b1; n++) @(negedge I_CLOCK);
    check({O_CD, O_IO}, 2'b11);
    check({O_TX_PARITY, O_TX_DATA}, nak ? {NAK_PAR, NAK_CODE} : {ACK_PAR, ACK_CODE});
    for (n = 0; n < 20 && O_BUS_FREE !== 1'b1; n++) @(negedge I_CLOCK);
    check({O_BUS_FREE, O_CD, O_IO, O_DELIVER}, {3'b100, !nak && rsv == 5'h00});
    check(init_u.reply, nak ? NAK_CODE : ACK_CODE);
    if (nak) naks++;
    else if (rsv == 5'h00) dlv++;
    if (!nak && rsv == 5'h00) begin
      n = len > limit ? limit : len;
      check({O_OVERSIZE, O_DELIVER_LEN}, {len > limit, n[12:0]});
      check(got.size(), n);
      foreach (got[k]) check(got[k], sent[k]);
    end
  endtask
  initial begin
    repeat (4) @(posedge I_CLOCK);
    I_RESET <= 1'b0;
    axr(REG_CFG, NODE_ID_RESET);
    axr(REG_LIMIT, LIMIT_RESET);
    axr(4'h2, 32'h00000000);
    node = 3'($random(seed));
    iid = 3'($random(seed));
    axw(REG_CFG, node);
    axr(REG_CFG, node);
    foreach (ofs_list[i]) begin
      frame(OPCODE_RECV, ofs_list[i], node, iid, 5'h00,
          2 + $unsigned($random(seed)) % 19, 0);
    end
    for (int i = 0; i < 9; i++) begin
      frame(i == 0 ? 8'hE1 : OPCODE_RECV, i == 1 ? 4'h5 : OFS_C, node ^ 3'(i == 2),
          iid ^ 3'(i == 3), i == 0 ? 5'h1F : 5'h00, 4, i < 4 ? 0 : i - 3);
    end
    for (int i = 0; i < 3; i++) begin
      rsv_at = i == 2 ? 5 : i + 2;
      frame(OPCODE_RECV, OFS_C, node, iid, 5'h08, 3, 0);
    end
    rsv_at = 2;
    axr(REG_STATUS, 32'h00000021);
    frame(OPCODE_RECV, OFS_C, node, iid, 5'h00, 6, 2);
    axr(REG_STATUS, 32'h00000011);
    limit = 13'h0003;
    axw(REG_LIMIT, limit);
    frame(OPCODE_RECV, OFS_B, node, iid, 5'h00, 3, 0);
    frame(OPCODE_RECV, OFS_B, node, iid, 5'h00, 5, 0);
    limit = LIMIT_RESET;
    axw(REG_LIMIT, limit);
    frame(OPCODE_RECV, OFS_C, node, iid, 5'h00, 8191, 0);
    axr(REG_STATUS, 32'h00000001);
    axr(REG_COUNT, {16'(naks), 16'(dlv)});
    results();
  end
endmodule
`default_nettype wire
